// ==== hdl/atsc_defs.svh ====
// atsc_defs.svh - offsets, field positions, reset values and codes of the
// converter and touch-screen control block.
// assumes: included by bare name by the package and by the atsc_top module.
`ifndef ATSC_DEFS_SVH
`define ATSC_DEFS_SVH

// ==========================================================================
// register offsets at the register port
`define ATSC_ADDR_CFG 8'h07
`define ATSC_ADDR_MODE 8'h08
`define ATSC_ADDR_RES_LO 8'h09
`define ATSC_ADDR_RES_HI 8'h0A

// ==========================================================================
// field positions in converter_channel_config and in the mode register
`define ATSC_CFG_EN_BIT 7
`define ATSC_CFG_START_BIT 6
`define ATSC_CFG_DONE_BIT 5
`define ATSC_CFG_REF_BIT 4
`define ATSC_CFG_SEL_MSB 3
`define ATSC_CFG_SEL_LSB 0
`define ATSC_MODE_MSB 2
`define ATSC_MODE_LSB 0

// ==========================================================================
// values reloaded on reset and, except the result, on undervoltage lockout
`define ATSC_CFG_RESET 8'h20
`define ATSC_MODE_RESET 3'h7
`define ATSC_RESULT_RESET 10'h000

// ==========================================================================
// channel codes
`define ATSC_CH_HIGH_FIRST 4'h6
`define ATSC_CH_HIGH_LAST 4'hC
`define ATSC_CH_RESERVED 4'hD
`define ATSC_CH_TOUCH_ALL 4'hE
`define ATSC_CH_TOUCH_XY 4'hF

// ==========================================================================
// touch drive mode codes
`define ATSC_TM_XPOS 3'h0
`define ATSC_TM_YPOS 3'h1
`define ATSC_TM_PRESS 3'h2
`define ATSC_TM_PLATE_X 3'h3
`define ATSC_TM_PLATE_Y 3'h4
`define ATSC_TM_STANDBY 3'h5
`define ATSC_TM_ADC 3'h6
`define ATSC_TM_OFF 3'h7

`endif

// ==== hdl/atsc_pkg.sv ====
// atsc_pkg.sv - types of the converter and touch-screen control block.
// assumes: compiled before every design module; holds no numbers of its own.
`include "atsc_defs.svh"

package atsc_pkg;

	// ======================================================================
	// conversion sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_BUSY,
		ST_RELEASE
	} atsc_state_t;

	// ======================================================================
	// what a panel pin is connected to
	typedef enum logic [2:0] {
		PIN_OPEN,
		PIN_HIZ,
		PIN_REF,
		PIN_GND,
		PIN_SENSE,
		PIN_BIAS
	} atsc_drive_t;

	// ======================================================================
	// whole state of the control block
	typedef struct packed {
		atsc_state_t state;
		logic cfg_en;
		logic cfg_start;
		logic cfg_done;
		logic cfg_ref;
		logic [3:0] cfg_sel;
		logic [2:0] mode;
		logic [9:0] result;
		logic [7:0] rd_data;
		logic range_high;
		logic tsc_en;
		logic tsc_xy_only;
		logic tsc_owns;
		logic detect_en;
		atsc_drive_t x_first;
		atsc_drive_t x_second;
		atsc_drive_t y_first;
		atsc_drive_t y_second;
	} atsc_regs_t;

	// ======================================================================
	// whole state of one input synchroniser
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} atsc_sync_state_t;

endpackage : atsc_pkg

// ==== hdl/atsc_sync.sv ====
// atsc_sync.sv - three-stage synchroniser for one input from outside mclk_i.
// assumes: async_i may change at any time; sync_o follows on mclk_i.
`timescale 1ns/100ps
`default_nettype none

module atsc_sync (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic async_i,
	output logic sync_o
);

	atsc_pkg::atsc_sync_state_t r_ff;
	atsc_pkg::atsc_sync_state_t nxt_r;

	// ======================================================================
	// shift chain; a change counts once stages two and three agree
	always_comb begin
		nxt_r = r_ff;
		nxt_r.s1 = async_i;
		nxt_r.s2 = r_ff.s1;
		nxt_r.s3 = r_ff.s2;
		if (r_ff.s2 == r_ff.s3) begin
			nxt_r.level = r_ff.s3;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			r_ff <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign sync_o = r_ff.level;

endmodule : atsc_sync

`default_nettype wire

// ==== hdl/atsc_top.sv ====
// atsc_top.sv - register and sequencing logic of the ten-bit converter and
// its touch-screen front end: channel select, panel pin drive, start/done
// handshake with the analog core, result registers.
// assumes: register port synchronous to mclk_i; undervoltage lockout and the
// analog core's done come from outside the clock domain.
//
// Contract
// - converter power follows the enable bit only.
// - writing start with enable set launches a conversion; bit self-clears on completion.
// - done flag is read-only, zero while converting, one when finished.
// - reference enable bit drives reference regulator independently.
// - codes 0..5 select low-range inputs.
// - codes 6..12 select high-range inputs.
// - code 14 hands converter to touch controller; 15 for x/y only.
// - mode 7 opens all pins, touch off; mode 6 routes pins to converter.
// - modes 0 and 1 drive x/y position patterns.
// - modes 2,3,4 drive pressure and plate patterns.
// - mode 5 standby biases x pins, grounds y pins for detection.
// - low result register holds result bits 7..0.
// - high result register holds bits 9..8 low, upper bits zero.
// - undervoltage lockout reloads config, done set, mode all ones.
`timescale 1ns/100ps
`default_nettype none
`include "atsc_defs.svh"

module atsc_top (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic undervoltage_lockout_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic adc_power_o,
	output logic ref_enable_o,
	output logic [3:0] adc_channel_o,
	output logic range_high_o,
	output logic adc_start_o,
	input wire logic adc_done_i,
	input wire logic [9:0] adc_result_i,
	output logic tsc_enable_o,
	output logic tsc_xy_only_o,
	output logic tsc_owns_adc_o,
	output logic touch_detect_en_o,
	output logic [2:0] panel_x_first_o,
	output logic [2:0] panel_x_second_o,
	output logic [2:0] panel_y_first_o,
	output logic [2:0] panel_y_second_o
);

	atsc_pkg::atsc_regs_t r_ff;
	atsc_pkg::atsc_regs_t nxt_r;
	logic undervoltage_lockout_sync;
	logic done_sync;
	logic wr_cfg;
	logic wr_mode;

	// ======================================================================
	// lockout defaults held as a vector so that single fields can be picked out
	localparam logic [7:0] CFG_DEFAULTS = `ATSC_CFG_RESET;

	// ======================================================================
	// synchronisers for lockout and the analog core's done
	atsc_sync u_undervoltage_lockout_sync (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.async_i(undervoltage_lockout_i),
		.sync_o(undervoltage_lockout_sync)
	);

	atsc_sync u_done_sync (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.async_i(adc_done_i),
		.sync_o(done_sync)
	);

	// ======================================================================
	// register write decode
	assign wr_cfg = reg_wr_i && (reg_addr_i == `ATSC_ADDR_CFG);
	assign wr_mode = reg_wr_i && (reg_addr_i == `ATSC_ADDR_MODE);

	// ======================================================================
	// next state: register writes, sequencer, decoders, read data
	always_comb begin
		nxt_r = r_ff;

		// read data for the addressed register, one cycle later
		case (reg_addr_i)
			`ATSC_ADDR_CFG: begin
				nxt_r.rd_data = {r_ff.cfg_en, r_ff.cfg_start, r_ff.cfg_done,
					r_ff.cfg_ref, r_ff.cfg_sel};
			end
			`ATSC_ADDR_MODE: begin
				nxt_r.rd_data = {5'h00, r_ff.mode};
			end
			`ATSC_ADDR_RES_LO: begin
				nxt_r.rd_data = r_ff.result[7:0];
			end
			`ATSC_ADDR_RES_HI: begin
				nxt_r.rd_data = {6'h00, r_ff.result[9:8]};
			end
			default: begin
				nxt_r.rd_data = 8'h00;
			end
		endcase

		if (undervoltage_lockout_sync) begin
			nxt_r.cfg_en = CFG_DEFAULTS[`ATSC_CFG_EN_BIT];
			nxt_r.cfg_start = CFG_DEFAULTS[`ATSC_CFG_START_BIT];
			nxt_r.cfg_done = CFG_DEFAULTS[`ATSC_CFG_DONE_BIT];
			nxt_r.cfg_ref = CFG_DEFAULTS[`ATSC_CFG_REF_BIT];
			nxt_r.cfg_sel = CFG_DEFAULTS[`ATSC_CFG_SEL_MSB:`ATSC_CFG_SEL_LSB];
			nxt_r.mode = `ATSC_MODE_RESET;
			nxt_r.state = atsc_pkg::ST_IDLE;
		end else begin
			// writable fields; the done flag is not writable
			if (wr_cfg) begin
				nxt_r.cfg_en = reg_wdata_i[`ATSC_CFG_EN_BIT];
				nxt_r.cfg_ref = reg_wdata_i[`ATSC_CFG_REF_BIT];
				nxt_r.cfg_sel = reg_wdata_i[`ATSC_CFG_SEL_MSB:`ATSC_CFG_SEL_LSB];
			end
			if (wr_mode) begin
				nxt_r.mode = reg_wdata_i[`ATSC_MODE_MSB:`ATSC_MODE_LSB];
			end

			// conversion sequencer
			case (r_ff.state)
				atsc_pkg::ST_IDLE: begin
					if (wr_cfg && reg_wdata_i[`ATSC_CFG_START_BIT] && nxt_r.cfg_en) begin
						nxt_r.cfg_start = 1'b1;
						nxt_r.cfg_done = 1'b0;
						nxt_r.state = atsc_pkg::ST_BUSY;
					end
				end
				atsc_pkg::ST_BUSY: begin
					if (!nxt_r.cfg_en) begin
						// disabled mid-conversion: abandon, result kept
						nxt_r.cfg_start = 1'b0;
						nxt_r.state = atsc_pkg::ST_RELEASE;
					end else if (done_sync) begin
						nxt_r.result = adc_result_i;
						nxt_r.cfg_start = 1'b0;
						nxt_r.cfg_done = 1'b1;
						nxt_r.state = atsc_pkg::ST_RELEASE;
					end
				end
				atsc_pkg::ST_RELEASE: begin
					// wait for the core to drop done before a new start
					if (!done_sync) begin
						nxt_r.state = atsc_pkg::ST_IDLE;
					end
				end
				default: begin
					nxt_r.state = atsc_pkg::ST_IDLE;
				end
			endcase
		end

		nxt_r.range_high = (nxt_r.cfg_sel >= `ATSC_CH_HIGH_FIRST) &&
			(nxt_r.cfg_sel <= `ATSC_CH_HIGH_LAST);
		nxt_r.tsc_owns = (nxt_r.cfg_sel == `ATSC_CH_TOUCH_ALL) ||
			(nxt_r.cfg_sel == `ATSC_CH_TOUCH_XY);
		nxt_r.tsc_xy_only = (nxt_r.cfg_sel == `ATSC_CH_TOUCH_XY);
		// touch controller off in mode 7
		nxt_r.tsc_en = (nxt_r.mode != `ATSC_TM_OFF);
		nxt_r.detect_en = (nxt_r.mode == `ATSC_TM_STANDBY);

		// panel pin drive from touch mode
		case (nxt_r.mode)
			`ATSC_TM_XPOS: begin
				nxt_r.x_first = atsc_pkg::PIN_REF;
				nxt_r.x_second = atsc_pkg::PIN_GND;
				nxt_r.y_first = atsc_pkg::PIN_SENSE;
				nxt_r.y_second = atsc_pkg::PIN_HIZ;
			end
			`ATSC_TM_YPOS: begin
				nxt_r.x_first = atsc_pkg::PIN_SENSE;
				nxt_r.x_second = atsc_pkg::PIN_HIZ;
				nxt_r.y_first = atsc_pkg::PIN_REF;
				nxt_r.y_second = atsc_pkg::PIN_GND;
			end
			`ATSC_TM_PRESS: begin
				nxt_r.x_first = atsc_pkg::PIN_REF;
				nxt_r.x_second = atsc_pkg::PIN_REF;
				nxt_r.y_first = atsc_pkg::PIN_GND;
				nxt_r.y_second = atsc_pkg::PIN_GND;
			end
			`ATSC_TM_PLATE_X: begin
				nxt_r.x_first = atsc_pkg::PIN_REF;
				nxt_r.x_second = atsc_pkg::PIN_GND;
				nxt_r.y_first = atsc_pkg::PIN_HIZ;
				nxt_r.y_second = atsc_pkg::PIN_HIZ;
			end
			`ATSC_TM_PLATE_Y: begin
				nxt_r.x_first = atsc_pkg::PIN_HIZ;
				nxt_r.x_second = atsc_pkg::PIN_HIZ;
				nxt_r.y_first = atsc_pkg::PIN_REF;
				nxt_r.y_second = atsc_pkg::PIN_GND;
			end
			`ATSC_TM_STANDBY: begin
				nxt_r.x_first = atsc_pkg::PIN_BIAS;
				nxt_r.x_second = atsc_pkg::PIN_BIAS;
				nxt_r.y_first = atsc_pkg::PIN_GND;
				nxt_r.y_second = atsc_pkg::PIN_GND;
			end
			`ATSC_TM_ADC: begin
				nxt_r.x_first = atsc_pkg::PIN_SENSE;
				nxt_r.x_second = atsc_pkg::PIN_SENSE;
				nxt_r.y_first = atsc_pkg::PIN_SENSE;
				nxt_r.y_second = atsc_pkg::PIN_SENSE;
			end
			default: begin
				nxt_r.x_first = atsc_pkg::PIN_OPEN;
				nxt_r.x_second = atsc_pkg::PIN_OPEN;
				nxt_r.y_first = atsc_pkg::PIN_OPEN;
				nxt_r.y_second = atsc_pkg::PIN_OPEN;
			end
		endcase
	end

	// ======================================================================
	// state register; reset values equal the lockout defaults
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			r_ff <= '{
				state: atsc_pkg::ST_IDLE,
				cfg_en: 1'b0,
				cfg_start: 1'b0,
				cfg_done: 1'b1,
				cfg_ref: 1'b0,
				cfg_sel: 4'h0,
				mode: `ATSC_MODE_RESET,
				result: `ATSC_RESULT_RESET,
				rd_data: 8'h00,
				range_high: 1'b0,
				tsc_en: 1'b0,
				tsc_xy_only: 1'b0,
				tsc_owns: 1'b0,
				detect_en: 1'b0,
				x_first: atsc_pkg::PIN_OPEN,
				x_second: atsc_pkg::PIN_OPEN,
				y_first: atsc_pkg::PIN_OPEN,
				y_second: atsc_pkg::PIN_OPEN
			};
		end else begin
			r_ff <= nxt_r;
		end
	end

	// ======================================================================
	// outputs
	assign reg_rdata_o = r_ff.rd_data;
	assign adc_power_o = r_ff.cfg_en;
	assign ref_enable_o = r_ff.cfg_ref;
	assign adc_channel_o = r_ff.cfg_sel;
	assign range_high_o = r_ff.range_high;
	assign adc_start_o = (r_ff.state == atsc_pkg::ST_BUSY);
	assign tsc_enable_o = r_ff.tsc_en;
	assign tsc_xy_only_o = r_ff.tsc_xy_only;
	assign tsc_owns_adc_o = r_ff.tsc_owns;
	assign touch_detect_en_o = r_ff.detect_en;
	assign panel_x_first_o = r_ff.x_first;
	assign panel_x_second_o = r_ff.x_second;
	assign panel_y_first_o = r_ff.y_first;
	assign panel_y_second_o = r_ff.y_second;

endmodule : atsc_top

`default_nettype wire

// ==== test/atsc_core_model.sv ====
// atsc_core_model.sv - analog converter core answering start with done.
// assumes: value and delay set by the bench before each start.
`timescale 1ns/100ps
`default_nettype none
module atsc_core_model (
	input wire logic mclk_i,
	input wire logic start_i,
	input wire logic [9:0] value_i,
	input wire logic [7:0] delay_i,
	output logic done_o,
	output logic [9:0] result_o
);
	logic [7:0] cnt = 8'h00;
	initial done_o = 1'b0;
	initial result_o = 10'h3FF;
	// ========
	// convert, hold result while done, scramble it once released
	always @(posedge mclk_i) begin
		if (done_o) begin
			if (!start_i) begin
				done_o <= #1 1'b0;
				result_o <= #1 ~result_o;
			end
		end else if (start_i) begin
			cnt <= cnt + 8'h01;
			if (cnt >= delay_i) begin
				done_o <= #1 1'b1;
				result_o <= #1 value_i;
				cnt <= 8'h00;
			end
		end else begin
			cnt <= 8'h00;
		end
	end
endmodule : atsc_core_model
`default_nettype wire

// ==== test/atsc_top_chk.sv ====
// atsc_top_chk.sv - port assertions of the converter control block.
// assumes: bound into atsc_top, one clock domain on mclk_i.
`timescale 1ns/100ps
`default_nettype none
module atsc_top_chk (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic undervoltage_lockout_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic adc_power_o,
	input wire logic ref_enable_o,
	input wire logic [3:0] adc_channel_o,
	input wire logic range_high_o,
	input wire logic adc_start_o,
	input wire logic adc_done_i,
	input wire logic tsc_enable_o,
	input wire logic tsc_xy_only_o,
	input wire logic tsc_owns_adc_o,
	input wire logic [2:0] panel_x_first_o,
	input wire logic [2:0] panel_x_second_o,
	input wire logic [2:0] panel_y_first_o,
	input wire logic [2:0] panel_y_second_o
);
	// ========
	// power, reference and channel fields of a config write
	logic [5:0] wsel;
	assign wsel = {reg_wdata_i[7], reg_wdata_i[4:0]};
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	property p_power; adc_start_o |-> adc_power_o; endproperty
	a_power: assert property (p_power) else $error("request while unpowered");
	// launch only from an enabled start write
	property p_launch;
		$rose(adc_start_o) |-> $past(reg_wr_i) && $past(reg_addr_i) == 8'h07
			&& $past(reg_wdata_i) >= 8'hC0;
	endproperty
	a_launch: assert property (p_launch) else $error("launch without start");
	// request ends soon after core done
	property p_clear; adc_start_o && adc_done_i |-> ##[1:6] !adc_start_o; endproperty
	a_clear: assert property (p_clear) else $error("start not cleared");
	property p_cfg;
		(!undervoltage_lockout_i)[*6] ##0 (reg_wr_i && reg_addr_i == 8'h07)
			|=> {adc_power_o, ref_enable_o, adc_channel_o} == $past(wsel);
	endproperty
	a_cfg: assert property (p_cfg) else $error("config write lost");
	property p_undervoltage_lockout;
		undervoltage_lockout_i[*6] |=> !adc_power_o && !adc_start_o && !tsc_enable_o && !ref_enable_o;
	endproperty
	a_undervoltage_lockout: assert property (p_undervoltage_lockout) else $error("lockout kept config");
	property p_range; range_high_o == (adc_channel_o >= 4'h6 && adc_channel_o <= 4'hC); endproperty
	a_range: assert property (p_range) else $error("wrong range");
	property p_tsc;
		tsc_owns_adc_o == (adc_channel_o >= 4'hE) && tsc_xy_only_o == (adc_channel_o == 4'hF);
	endproperty
	a_tsc: assert property (p_tsc) else $error("wrong touch ownership");
	property p_off;
		!tsc_enable_o |-> {panel_x_first_o, panel_x_second_o, panel_y_first_o,
			panel_y_second_o} == 12'h000;
	endproperty
	a_off: assert property (p_off) else $error("pins driven while off");
endmodule : atsc_top_chk
bind atsc_top atsc_top_chk u_atsc_top_chk (.mclk_i, .rst_b_i, .undervoltage_lockout_i, .reg_wr_i,
	.reg_addr_i, .reg_wdata_i, .adc_power_o, .ref_enable_o, .adc_channel_o, .range_high_o,
	.adc_start_o, .adc_done_i, .tsc_enable_o, .tsc_xy_only_o, .tsc_owns_adc_o,
	.panel_x_first_o, .panel_x_second_o, .panel_y_first_o, .panel_y_second_o);
`default_nettype wire

// ==== test/atsc_top_tb.sv ====
// atsc_top_tb.sv - register-level tests of the converter control block.
// assumes: core model on the converter side, 200 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module atsc_top_tb;
	logic mclk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic undervoltage_lockout_i = 1'b0;
	logic reg_wr_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic [7:0] reg_rdata_o, rd, cfg;
	logic adc_power_o, ref_enable_o, range_high_o, adc_start_o, adc_done_i;
	logic tsc_enable_o, tsc_xy_only_o, tsc_owns_adc_o, touch_detect_en_o;
	logic [3:0] adc_channel_o;
	logic [9:0] adc_result_i;
	logic [9:0] conv_value = 10'h000;
	logic [7:0] conv_delay = 8'h04;
	logic [2:0] px1, px2, py1, py2;
	int n_errors = 0;
	int cmp_count = 0;
	// expected pins per mode: x first, x second, y first, y second
	logic [15:0] pins [8] = '{16'h2341, 16'h4123, 16'h2233, 16'h2311, 16'h1123,
		16'h5533, 16'h4444, 16'h0000};
	always #2.5 mclk_i = ~mclk_i;
	atsc_top u_atsc_top (.mclk_i, .rst_b_i, .undervoltage_lockout_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
		.reg_rdata_o, .adc_power_o, .ref_enable_o, .adc_channel_o, .range_high_o,
		.adc_start_o, .adc_done_i, .adc_result_i, .tsc_enable_o, .tsc_xy_only_o,
		.tsc_owns_adc_o, .touch_detect_en_o, .panel_x_first_o(px1),
		.panel_x_second_o(px2), .panel_y_first_o(py1), .panel_y_second_o(py2));
	atsc_core_model u_atsc_core_model (.mclk_i, .start_i(adc_start_o), .value_i(conv_value),
		.delay_i(conv_delay), .done_o(adc_done_i), .result_o(adc_result_i));
	// ========
	// verdict, compares and register access
	task automatic give_verdict;
		if (n_errors == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : give_verdict
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_reg
	task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_pin
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		#1;
		reg_wr_i = 1'b1;
		reg_addr_i = a;
		reg_wdata_i = d;
		@(posedge mclk_i);
		#1;
		reg_wr_i = 1'b0;
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk_i);
		#1;
		reg_addr_i = a;
		@(posedge mclk_i);
		#1;
		rd = reg_rdata_o;
		chk_reg(rd, exp);
	endtask : rd_chk
	task automatic poll_done;
		for (int i = 0; i < 100; i++) begin
			@(posedge mclk_i);
			#1;
			reg_addr_i = 8'h07;
			@(posedge mclk_i);
			#1;
			if (reg_rdata_o[5] === 1'b1) return;
		end
		n_errors++;
		give_verdict();
	endtask : poll_done
	// ========
	// main sequence
	initial begin
		repeat (6) @(posedge mclk_i);
		#1;
		rst_b_i = 1'b1;
		rd_chk(8'h07, 8'h20);
		rd_chk(8'h08, 8'h07);
		rd_chk(8'h0A, 8'h00);
		rd_chk(8'h0B, 8'h00);
		wr(8'h09, 8'hFF);
		rd_chk(8'h09, 8'h00);
		wr(8'h07, 8'h40);
		rd_chk(8'h07, 8'h20);
		// every code but the reserved one, reference toggling
		for (int c = 0; c < 16; c++) begin
			if (c == 13) continue;
			wr(8'h07, {3'b000, c[0], c[3:0]});
			chk_pin({7'h00, adc_power_o, ref_enable_o, range_high_o, tsc_owns_adc_o,
				tsc_xy_only_o, adc_channel_o}, {7'h00, 1'b0, c[0], (c >= 6 && c <= 12),
				(c >= 14), (c == 15), c[3:0]});
			rd_chk(8'h07, {3'b001, c[0], c[3:0]});
		end
		// every touch mode, upper bits read zero
		for (int m = 0; m < 8; m++) begin
			wr(8'h08, {5'b11111, m[2:0]});
			chk_pin({1'b0, px1, 1'b0, px2, 1'b0, py1, 1'b0, py2}, pins[m]);
			chk_pin({14'h0000, tsc_enable_o, touch_detect_en_o},
				{14'h0000, (m != 7), (m == 5)});
			rd_chk(8'h08, {5'b00000, m[2:0]});
		end
		// plain then touch conversion, prompt then slow core
		wr(8'h08, 8'h00);
		for (int k = 0; k < 2; k++) begin
			conv_value = k ? 10'h35A : 10'h2A5;
			conv_delay = k ? 8'h28 : 8'h04;
			cfg = k ? 8'h9E : 8'h93;
			wr(8'h07, cfg);
			wr(8'h07, cfg | 8'h40);
			chk_pin({15'h0000, adc_start_o}, 16'h0001);
			rd_chk(8'h07, cfg | 8'h40);
			poll_done();
			rd_chk(8'h07, cfg | 8'h20);
			rd_chk(8'h09, conv_value[7:0]);
			rd_chk(8'h0A, {6'h00, conv_value[9:8]});
		end
		// abort by clearing enable mid conversion
		wr(8'h07, 8'hD3);
		wr(8'h07, 8'h13);
		chk_pin({15'h0000, adc_start_o}, 16'h0000);
		rd_chk(8'h07, 8'h13);
		rd_chk(8'h09, 8'h5A);
		wr(8'h08, 8'h02);
		undervoltage_lockout_i = 1'b1;
		repeat (8) @(posedge mclk_i);
		wr(8'h07, 8'h90);
		rd_chk(8'h07, 8'h20);
		rd_chk(8'h08, 8'h07);
		rd_chk(8'h09, 8'h5A);
		chk_pin({15'h0000, tsc_enable_o}, 16'h0000);
		undervoltage_lockout_i = 1'b0;
		repeat (8) @(posedge mclk_i);
		wr(8'h07, 8'h80);
		chk_pin({15'h0000, adc_power_o}, 16'h0001);
		give_verdict();
	end
endmodule : atsc_top_tb
`default_nettype wire
